/* File: core/cetu_pkg.sv */
package cetu_pkg;

  // status word field positions
  localparam int unsigned SW_NMA_BIT  = 7;  // nonmask_active_flag
  localparam int unsigned SW_INH_BIT  = 6;  // in_handler_flag
  localparam int unsigned SW_IBLK_BIT = 5;  // intr_block_flag
  localparam logic [31:0] SW_RESET   = 32'h0000_0020;

  // handler addresses
  localparam logic [31:0] VEC_SOFT_LO = 32'h0000_0040;
  localparam logic [31:0] VEC_SOFT_HI = 32'h0000_0050;
  localparam logic [31:0] VEC_DEBUG   = 32'h0000_0060;
  localparam logic [31:0] PC_RESET    = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD   = 32'h0000_0000;

  // illegal opcode pattern fields
  localparam int unsigned OPC_HI     = 10;
  localparam int unsigned OPC_LO     = 5;
  localparam logic [5:0]  OPC_ILL    = 6'h3f;
  localparam int unsigned SUB_HI     = 26;
  localparam int unsigned SUB_LO     = 23;
  localparam logic [3:0]  SUB_MIN    = 4'h7;
  localparam int unsigned SUB_BIT    = 16;

  // soft vector range split
  localparam logic [4:0]  VEC_SPLIT  = 5'h10;
  localparam logic [15:0] CAUSE_SOFT_BASE = 16'h0040;
  localparam logic [15:0] CAUSE_BAD_OP    = 16'h0060;

  // action selected in one cycle
  typedef enum logic [2:0] {
    CETU_ACT_NONE,
    CETU_ACT_SOFT,
    CETU_ACT_BADOP,
    CETU_ACT_DBRK,
    CETU_ACT_HRET,
    CETU_ACT_DGRET
  } cetu_act_t;

  // instruction presented by the pipeline
  typedef struct packed {
    logic        valid;     // an instruction executes this cycle
    logic [31:0] word;      // instruction word
    logic [31:0] next_pc;   // restored pc for this instruction
    logic        is_trap;   // software exception instruction
    logic [4:0]  vector;    // trap vector operand
    logic        is_hret;   // return_from_handler
    logic        is_dbrk;   // debug_break_instr
    logic        is_dgret;  // debug_return_instr
  } cetu_instr_t;

  // redirect presented back to the pipeline
  typedef struct packed {
    logic        valid;
    logic [31:0] pc;
  } cetu_redir_t;

endpackage : cetu_pkg

/* File: core/cetu_decode.sv */
`timescale 1ns/1ps
module cetu_decode
  import cetu_pkg::*;
(
  input  wire cetu_instr_t instr,     // instruction in execute
  input  wire logic        in_handler, // in_handler_flag now
  output cetu_act_t        act,       // selected action
  output logic             bad_op     // illegal pattern seen
);

  // illegal opcode classifier
  function automatic logic is_bad(input logic [31:0] w);
    is_bad = (w[OPC_HI:OPC_LO] == OPC_ILL) && (w[SUB_HI:SUB_LO] >= SUB_MIN) && !w[SUB_BIT];
  endfunction : is_bad

  ////////////////////////////////////////////////////////////////////////////
  // action priority: illegal pattern wins over any other decode
  always_comb
  begin
    bad_op = instr.valid && is_bad(instr.word);
    act    = CETU_ACT_NONE;
    if (bad_op)
      act = CETU_ACT_BADOP;
    else if (!instr.valid)
      act = CETU_ACT_NONE;
    else if (instr.is_dbrk)
      act = CETU_ACT_DBRK;
    else if (instr.is_trap)
      act = CETU_ACT_SOFT;
    else if (instr.is_dgret)
      act = CETU_ACT_DGRET;
    else if (instr.is_hret && in_handler)
      act = CETU_ACT_HRET;
  end

endmodule : cetu_decode

/* File: core/cetu_trap_unit.sv */
`timescale 1ns/1ps
module cetu_trap_unit
  import cetu_pkg::*;
(
  input  wire  logic        sys_clk,      // cpu clock
  input  wire  logic        rst_n,        // async reset, active low
  input  wire  logic        clk_en,       // freezes all state when low
  input  wire  cetu_instr_t instr,        // instruction in execute
  input  wire  logic        sw_wr,        // load_system_reg_instr write to status word
  input  wire  logic [31:0] sw_wdata,     // write data for status word
  input  wire  logic        dsave_wr_pc,  // system write to debug_save_pc
  input  wire  logic        dsave_wr_sw,  // system write to debug_save_status
  input  wire  logic [31:0] dsave_wdata,  // write data for debug saves
  output cetu_redir_t       redir,        // pc redirect to fetch
  output logic              squash,       // instruction must not commit
  output logic              intr_hold,    // no interrupt may be taken
  output logic [31:0]       status_word,  // current status word
  output logic [31:0]       soft_save_pc,
  output logic [31:0]       soft_save_status,
  output logic [31:0]       cause_register,
  output logic [31:0]       debug_save_pc,     // reads zero outside window
  output logic [31:0]       debug_save_status, // reads zero outside window
  output logic              debug_window  // debug saves accessible
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [31:0] sw_q, sw_d;          // status word
  logic [31:0] spc_q, spc_d;        // soft save pc
  logic [31:0] ssw_q, ssw_d;        // soft save status
  logic [31:0] cause_q, cause_d;    // cause register
  logic [31:0] dpc_q, dpc_d;        // debug save pc
  logic [31:0] dsw_q, dsw_d;        // debug save status
  logic        dwin_q, dwin_d;      // debug window open
  logic        rv_q, rv_d;          // redirect valid
  logic [31:0] rpc_q, rpc_d;        // redirect target
  cetu_act_t   act;                 // decoded action
  logic        bad_op;              // illegal pattern

  ////////////////////////////////////////////////////////////////////////////
  // decode of the executing instruction
  cetu_decode u_dec (
    .instr      (instr),
    .in_handler (sw_q[SW_INH_BIT]),
    .act        (act),
    .bad_op     (bad_op)
  );

  // flag-setting helper for trap entry
  function automatic logic [31:0] enter_flags(input logic [31:0] s, input logic np);
    logic [31:0] r;
    r = s;
    r[SW_INH_BIT]  = 1'b1;
    r[SW_IBLK_BIT] = 1'b1;
    if (np)
      r[SW_NMA_BIT] = 1'b1;
    return r;
  endfunction : enter_flags

  ////////////////////////////////////////////////////////////////////////////
  // next state: each entry is one atomic update
  always_comb
  begin
    sw_d   = sw_q;
    spc_d  = spc_q;
    ssw_d  = ssw_q;
    cause_d = cause_q;
    dpc_d  = dpc_q;
    dsw_d  = dsw_q;
    dwin_d = dwin_q;
    rv_d   = 1'b0;
    rpc_d  = rpc_q;
    // system register writes, only in cycles with no trap, break or return action
    if (act == CETU_ACT_NONE)
    begin
      if (sw_wr)
        sw_d = sw_wdata;
      if (dwin_q && dsave_wr_pc)
        dpc_d = dsave_wdata;
      if (dwin_q && dsave_wr_sw)
        dsw_d = dsave_wdata;
    end
    unique case (act)
      CETU_ACT_NONE:
        rv_d = 1'b0;
      CETU_ACT_SOFT:
      begin
        spc_d = instr.next_pc;
        ssw_d = sw_q;
        cause_d = {cause_q[31:16], CAUSE_SOFT_BASE | {11'h000, instr.vector}};
        sw_d  = enter_flags(sw_q, 1'b0);
        rv_d  = 1'b1;
        rpc_d = (instr.vector < VEC_SPLIT) ? VEC_SOFT_LO : VEC_SOFT_HI;
      end
      CETU_ACT_BADOP, CETU_ACT_DBRK:
      begin
        dpc_d  = instr.next_pc;
        dsw_d  = sw_q;
        sw_d   = enter_flags(sw_q, 1'b1);
        rv_d   = 1'b1;
        rpc_d  = VEC_DEBUG;
        // only a debug break opens the debug save window
        if (act == CETU_ACT_DBRK)
          dwin_d = 1'b1;
      end
      CETU_ACT_HRET:
      begin
        sw_d  = ssw_q;
        rv_d  = 1'b1;
        rpc_d = spc_q;
      end
      CETU_ACT_DGRET:
      begin
        sw_d   = dsw_q;
        rv_d   = 1'b1;
        rpc_d  = dpc_q;
        dwin_d = 1'b0;
      end
      default:
        rv_d = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers; frozen while clk_en is low
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q   <= SW_RESET;
      spc_q  <= PC_RESET;
      ssw_q  <= ZERO_WORD;
      cause_q <= ZERO_WORD;
      dpc_q  <= PC_RESET;
      dsw_q  <= ZERO_WORD;
      dwin_q <= 1'b0;
      rv_q   <= 1'b0;
      rpc_q  <= PC_RESET;
    end
    else if (clk_en)
    begin
      sw_q   <= sw_d;
      spc_q  <= spc_d;
      ssw_q  <= ssw_d;
      cause_q <= cause_d;
      dpc_q  <= dpc_d;
      dsw_q  <= dsw_d;
      dwin_q <= dwin_d;
      rv_q   <= rv_d;
      rpc_q  <= rpc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign redir.valid       = rv_q;
  assign redir.pc          = rpc_q;
  assign squash            = bad_op;
  assign intr_hold         = (act != CETU_ACT_NONE) || rv_q;
  assign status_word       = sw_q;
  assign soft_save_pc      = spc_q;
  assign soft_save_status  = ssw_q;
  assign cause_register    = cause_q;
  assign debug_save_pc     = dwin_q ? dpc_q : ZERO_WORD;
  assign debug_save_status = dwin_q ? dsw_q : ZERO_WORD;
  assign debug_window      = dwin_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  a_badop_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_BADOP) |=> (redir.valid && redir.pc == VEC_DEBUG))
    else $error("illegal op did not jump to debug vector");
  a_badop_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_BADOP) |=> (sw_q[SW_NMA_BIT] && sw_q[SW_INH_BIT] && sw_q[SW_IBLK_BIT]))
    else $error("trap flags not set");
  a_trap_save: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_BADOP) |=> (dpc_q == $past(instr.next_pc) && dsw_q == $past(sw_q)))
    else $error("debug save mismatch");
  a_dbrk_always: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (instr.valid && instr.is_dbrk && !bad_op) |-> act == CETU_ACT_DBRK)
    else $error("debug break not taken");
  a_hret_restore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_HRET) |=> (redir.pc == $past(spc_q) && sw_q == $past(ssw_q)))
    else $error("handler return restore wrong");
  a_dgret_restore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_DGRET) |=> (redir.pc == $past(dpc_q) && !dwin_q))
    else $error("debug return wrong");
  a_soft_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_SOFT && instr.vector >= VEC_SPLIT) |=> redir.pc == VEC_SOFT_HI)
    else $error("soft vector wrong");
  a_soft_flags: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_SOFT) |=> (sw_q[SW_INH_BIT] && sw_q[SW_IBLK_BIT] && spc_q == $past(instr.next_pc)))
    else $error("soft entry wrong");
  a_window_hide: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !dwin_q |-> (debug_save_pc == ZERO_WORD))
    else $error("debug save visible outside window");
  a_squash_bad: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (instr.valid && instr.word[OPC_HI:OPC_LO] == OPC_ILL && instr.word[SUB_HI:SUB_LO] >= SUB_MIN
     && !instr.word[SUB_BIT]) |-> squash)
    else $error("illegal op not squashed");
  // an illegal op entry keeps a closed window closed
  a_badop_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_BADOP && !dwin_q) |=> !dwin_q)
    else $error("illegal op opened debug window");
  // debug break opens the window
  a_dbrk_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_DBRK) |=> dwin_q)
    else $error("debug break left window closed");
  // debug break saves, flags and jumps in one step
  a_dbrk_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_DBRK) |=> (redir.pc == VEC_DEBUG && dpc_q == $past(instr.next_pc)
     && dsw_q == $past(sw_q) && sw_q[SW_NMA_BIT] && sw_q[SW_INH_BIT]))
    else $error("debug break entry wrong");
  // handler return outside a handler is ignored
  a_hret_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && instr.valid && instr.is_hret && !instr.is_trap && !instr.is_dbrk && !instr.is_dgret
     && !bad_op && !sw_q[SW_INH_BIT]) |=> !redir.valid)
    else $error("handler return taken outside handler");

  c_badop: cover property (@(posedge sys_clk) disable iff (!rst_n) clk_en && act == CETU_ACT_BADOP);
  c_dbrk_ret: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_DBRK) ##[1:20] (clk_en && act == CETU_ACT_DGRET));
  c_soft_hret: cover property (@(posedge sys_clk) disable iff (!rst_n)
    (clk_en && act == CETU_ACT_SOFT) ##[1:20] (clk_en && act == CETU_ACT_HRET));
  c_window_write: cover property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && dwin_q && dsave_wr_sw);

endmodule : cetu_trap_unit

/* File: testbench/cetu_pipe_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// stand-in for decode and execute: one instruction per call
module cetu_pipe_model
  import cetu_pkg::*;
(
  input  wire logic   sys_clk, // cpu clock
  output cetu_instr_t instr    // instruction in execute
);
  initial instr = '0;
  // launch just after an edge, held until the taking edge
  task present(input logic [31:0] w, input logic [31:0] pc, input logic [3:0] k, input logic [4:0] v);
    cetu_instr_t t;
    t = '{1'h1, w, pc, k[3], v, k[2], k[1], k[0]};
    @(posedge sys_clk);
    instr <= t;
  endtask : present
  // taking edge: drop valid, scramble the rest so stale fields never look good
  task retire();
    cetu_instr_t t;
    t = ~instr;
    t.valid = 1'h0;
    @(posedge sys_clk);
    instr <= t;
  endtask : retire
endmodule : cetu_pipe_model

/* File: testbench/cetu_trap_unit_tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// self-checking bench for the trap unit
module cetu_trap_unit_tb
  import cetu_pkg::*;
;
  logic        sys_clk = 1'h0;          // cpu clock
  logic        rst_n = 1'h0;            // async reset
  logic        clk_en = 1'h1;           // clock enable
  logic        sw_wr = 1'h0;            // status write strobe
  logic        dsave_wr_pc = 1'h0;      // debug pc write strobe
  logic        dsave_wr_sw = 1'h0;      // debug status write strobe
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic [31:0] dsave_wdata = 32'h0000_0000;
  cetu_instr_t instr;
  cetu_redir_t redir;
  logic        squash, intr_hold, debug_window;
  logic [31:0] status_word, soft_save_pc, soft_save_status, cause_register, debug_save_pc, debug_save_status;
  int          fail_count = 0;
  int          samples_checked = 0;
  always #25 sys_clk = ~sys_clk;
  cetu_pipe_model pipe (.sys_clk(sys_clk), .instr(instr));
  cetu_trap_unit uut (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .instr(instr), .sw_wr(sw_wr),
    .sw_wdata(sw_wdata), .dsave_wr_pc(dsave_wr_pc), .dsave_wr_sw(dsave_wr_sw), .dsave_wdata(dsave_wdata),
    .redir(redir), .squash(squash), .intr_hold(intr_hold), .status_word(status_word),
    .soft_save_pc(soft_save_pc), .soft_save_status(soft_save_status), .cause_register(cause_register),
    .debug_save_pc(debug_save_pc), .debug_save_status(debug_save_status), .debug_window(debug_window));
  ////////////////////////////////////////////////////////////////////////////////
  // compare and count
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one instruction; k = {trap, hret, dbrk, dgret}
  task run(input logic [31:0] w, pc, input logic [3:0] k, input logic [4:0] v, input logic sq, rv,
           input logic [31:0] tgt);
    pipe.present(w, pc, k, v);
    #1 chk(squash, sq);
    chk(intr_hold, rv);
    pipe.retire();
    #1 chk(redir.valid, rv);
    chk(intr_hold, rv);
    if (rv)
      chk(redir.pc, tgt);
  endtask : run
  // one-cycle strobe writes
  task wr(input logic [1:0] sel, input logic [31:0] d);
    @(posedge sys_clk);
    sw_wr <= sel == 2'h0;
    dsave_wr_pc <= sel == 2'h1;
    dsave_wr_sw <= sel == 2'h2;
    sw_wdata <= d;
    dsave_wdata <= d;
    @(posedge sys_clk);
    sw_wr <= 1'h0;
    dsave_wr_pc <= 1'h0;
    dsave_wr_sw <= 1'h0;
    #1;
  endtask : wr
  ////////////////////////////////////////////////////////////////////////////////
  // reset state
  task t_reset();
    chk(status_word, 32'h0000_0020);
    chk(redir.valid, 1'h0);
    chk(debug_window, 1'h0);
  endtask : t_reset
  // software exception entry, both vector halves, and return
  task t_soft();
    wr(2'h0, 32'h0000_0001);
    run(32'h0000_0000, 32'h0000_0104, 4'h8, 5'h0f, 1'h0, 1'h1, 32'h0000_0040);
    chk(soft_save_pc, 32'h0000_0104);
    chk(soft_save_status, 32'h0000_0001);
    chk(cause_register, 32'h0000_004f);
    chk(status_word, 32'h0000_0061);
    run(32'h0000_0000, 32'h0000_0000, 4'h4, 5'h00, 1'h0, 1'h1, 32'h0000_0104);
    chk(status_word, 32'h0000_0001);
    run(32'h0000_0000, 32'h0000_0000, 4'h4, 5'h00, 1'h0, 1'h0, 32'h0000_0000);
    run(32'h0000_0000, 32'h0000_0100, 4'h8, 5'h10, 1'h0, 1'h1, 32'h0000_0050);
    chk(cause_register, 32'h0000_0050);
  endtask : t_soft
  // near misses, then an illegal word that also claims to be a trap
  task t_badop();
    wr(2'h0, 32'h0000_0002);
    run(32'h0300_07e0, 32'h0000_0200, 4'h0, 5'h00, 1'h0, 1'h0, 32'h0000_0000);
    run(32'h0381_07e0, 32'h0000_0200, 4'h0, 5'h00, 1'h0, 1'h0, 32'h0000_0000);
    run(32'h0780_07c0, 32'h0000_0200, 4'h0, 5'h00, 1'h0, 1'h0, 32'h0000_0000);
    run(32'h0780_07e0, 32'h0000_0200, 4'h8, 5'h03, 1'h1, 1'h1, 32'h0000_0060);
    chk(debug_window, 1'h0);
    chk(debug_save_pc, 32'h0000_0000);
    chk(status_word, 32'h0000_00e2);
    chk(soft_save_pc, 32'h0000_0100);
    wr(2'h1, 32'h0000_0300);
    chk(debug_save_status, 32'h0000_0000);
    run(32'h0000_0000, 32'h0000_0000, 4'h1, 5'h00, 1'h0, 1'h1, 32'h0000_0200);
    chk(status_word, 32'h0000_0002);
    chk(debug_window, 1'h0);
    wr(2'h1, 32'h0000_0400);
    chk(debug_save_pc, 32'h0000_0000);
  endtask : t_badop
  // debug break with interrupts blocked, then debug return
  task t_dbrk();
    wr(2'h0, 32'h0000_0020);
    run(32'h0000_0000, 32'h0000_0500, 4'h2, 5'h00, 1'h0, 1'h1, 32'h0000_0060);
    chk(debug_save_pc, 32'h0000_0500);
    chk(debug_save_status, 32'h0000_0020);
    chk(status_word, 32'h0000_00e0);
    chk(debug_window, 1'h1);
    wr(2'h1, 32'h0000_0300);
    wr(2'h2, 32'h0000_0004);
    chk(debug_save_pc, 32'h0000_0300);
    chk(debug_save_status, 32'h0000_0004);
    run(32'h0000_0000, 32'h0000_0000, 4'h1, 5'h00, 1'h0, 1'h1, 32'h0000_0300);
    chk(status_word, 32'h0000_0004);
  endtask : t_dbrk
  // clock enable low: a soft trap presented then must leave no trace
  task t_freeze();
    @(posedge sys_clk);
    clk_en <= 1'h0;
    pipe.present(32'h0000_0000, 32'h0000_0700, 4'h8, 5'h01);
    pipe.retire();
    #1 chk(redir.valid, 1'h0);
    chk(soft_save_pc, 32'h0000_0100);
    chk(status_word, 32'h0000_0004);
    @(posedge sys_clk);
    clk_en <= 1'h1;
  endtask : t_freeze
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task final_report();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : final_report
  // hang guard, far beyond the few dozen cycles the tests need
  initial
  begin
    #200_000;
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    final_report();
  end
  // main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'h1;
    #1 t_reset();
    t_soft();
    t_badop();
    t_dbrk();
    t_freeze();
    final_report();
  end
endmodule : cetu_trap_unit_tb
